// file: hw/bp_debug_map.vh
// Constants for the breakpoint debug unit: register byte addresses,
// field positions, event codes and exception vectors.
// Assumes inclusion by the debug unit and its testbench; holds definitions alone.
`ifndef BP_DEBUG_MAP_VH
`define BP_DEBUG_MAP_VH

// Register byte addresses on the APB side.
`define A_BP_ADDR_ZERO   6'h00
`define A_BP_ADDR_ONE    6'h04
`define A_BP_ADDR_TWO    6'h08
`define A_BP_ADDR_THREE  6'h0C
`define A_ALIAS_FOUR     6'h10
`define A_ALIAS_FIVE     6'h14
`define A_DEBUG_STATUS   6'h18
`define A_DEBUG_CONTROL  6'h1C
`define A_CONTROL_FOUR   6'h20
`define A_IRQ_STATUS     6'h24
`define A_IRQ_ENABLE     6'h28
`define A_IRQ_CLEAR      6'h2C

// Word index of the alias and real status/control registers.
`define IDX_ALIAS_FOUR   4'h4
`define IDX_ALIAS_FIVE   4'h5
`define IDX_STATUS       4'h6
`define IDX_CONTROL      4'h7

// Debug control fields.
`define CTL_LOCAL_COMPAT  8
`define CTL_GLOBAL_COMPAT 9
`define CTL_GUARD         13
`define CTL_FIELD_BASE    16
`define CTL_WMASK         32'hFFFF23FF

// Debug status fields.
`define ST_ACCESS  13
`define ST_STEP    14
`define ST_TASK    15
`define ST_WMASK   32'h0000E00F

// Debug extension enable inside control register four.
`define CR4_DBG_EXT 3

// Breakpoint kind and size encodings.
`define KIND_EXEC   2'h0
`define KIND_WRITE  2'h1
`define KIND_IO     2'h2
`define KIND_RDWR   2'h3
`define SIZE_ONE    2'h0
`define SIZE_TWO    2'h1
`define SIZE_FOUR   2'h3

// Processor cycle kinds on the cycle port.
`define CYC_FETCH  2'h0
`define CYC_WRITE  2'h1
`define CYC_IO     2'h2
`define CYC_READ   2'h3

// Exception vectors.
`define VEC_DEBUG  8'h01
`define VEC_BREAK  8'h03
`define VEC_UNDEF  8'h06

// Interrupt status bits.
`define IRQ_DEBUG  0
`define IRQ_BREAK  1
`define IRQ_UNDEF  2

`endif

// file: hw/breakpoint_debug_unit.v
// Breakpoint debug unit: four address breakpoints, debug status and
// control, alias handling and debug exception requests.
// Assumes the core reports cycles, retirements and task switches on
// ref_clk_in, and that debug register instructions arrive over APB.
`timescale 1ns/100ps
`default_nettype none
`include "bp_debug_map.vh"

// Contract
// RQ1: Four 32-bit breakpoint address registers compared with cycle linear addresses.
// RQ2: With extensions off, alias four/five reach status/control registers.
// RQ3: With extensions on, any alias access raises undefined-opcode instead; here a guarded alias access faults on vector 01h.
// RQ4: An enabled breakpoint match sets its hit flag in status.
// RQ5: Disabled matching breakpoints set hit flags too, but raise no exception.
// RQ6: Guarded debug register access sets access flag, excepts before access.
// RQ7: Step flag set gives an exception per retired instruction, step flag.
// RQ8: Switch to a trapping task sets task flag and raises exception.
// RQ9: Local enables enable breakpoints; every task switch clears them.
// RQ10: Global enables survive task switches and override clear locals.
// RQ11: Compatibility bits are stored but change nothing.
// RQ12: Guard bit arms access detection; any debug exception clears it.
// RQ13: Kind field selects execute, write, port access or read/write.
// RQ14: Size field selects one, two or four bytes; 10b undefined.
// RQ15: Software pairs execute kind with one-byte size.
// RQ16: Port kind only valid with extensions on; else treated as no match.
// RQ17: Data, port, step and task events trap on vector 01h.
// RQ18: Execute breakpoints and access detection fault on vector 01h.
// RQ19: Opcode CCh traps on vector 03h after it executes; here it is dropped when a debug event falls in the same cycle.
module breakpoint_debug_unit (
    // Clock and reset.
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // APB slave.
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [5:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Processor cycle monitor.
    input  wire        cyc_valid_in,
    input  wire [1:0]  cyc_kind_in,
    input  wire [31:0] cyc_addr_in,
    // Instruction and task events.
    input  wire        insn_done_in,
    input  wire        step_flag_in,
    input  wire        brk_insn_done_in,
    input  wire        task_switch_in,
    input  wire        task_trap_in,
    // Exception request.
    output reg         exc_valid_out,
    output reg  [7:0]  exc_vector_out,
    output reg         exc_fault_out,
    output reg         irq_out
);

    // Match window check: the size field masks the low address bits.
    // A size of 10b is undefined and is compared here as a single byte.
    function hit;
        input [31:0] bp;
        input [1:0]  size;
        input [31:0] a;
        reg   [31:0] m;
        begin
            m = 32'hFFFFFFFF;
            if (size == `SIZE_TWO) begin
                m = 32'hFFFFFFFE; // RQ14
            end else if (size == `SIZE_FOUR) begin
                m = 32'hFFFFFFFC; // RQ14
            end
            hit = ((bp & m) == (a & m));
        end
    endfunction

    // Kind check between a breakpoint kind field and a cycle kind.
    // The port kind never matches with extensions off, so no stray trap follows.
    function kind_ok;
        input [1:0] kind;
        input [1:0] cyc;
        input       ext;
        begin
            case (kind)
                `KIND_EXEC:  kind_ok = (cyc == `CYC_FETCH); // RQ13
                `KIND_WRITE: kind_ok = (cyc == `CYC_WRITE); // RQ13
                `KIND_IO:    kind_ok = ext && (cyc == `CYC_IO); // RQ16
                default:     kind_ok = (cyc == `CYC_WRITE) || (cyc == `CYC_READ); // RQ13
            endcase
        end
    endfunction

    // Architectural state.
    // No reset values are documented; every register clears to zero here.
    reg [31:0] bp_addr [0:3];
    reg [31:0] debug_control;
    reg [31:0] debug_status;
    reg [31:0] control_reg_four;
    reg [2:0]  irq_status;
    reg [2:0]  irq_enable;
    reg        trap_pend;

    // Decoded views of debug control and control register four.
    wire       dbg_extensions_on      = control_reg_four[`CR4_DBG_EXT];
    wire       regaccess_guard_enable = debug_control[`CTL_GUARD];
    wire [3:0] local_bp_enables;
    wire [3:0] global_bp_enables;
    wire [7:0] bp_kind_fields;
    wire [7:0] bp_size_fields;

    // Each breakpoint has an enable pair in the low byte and a field nibble above bit 16.
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : field_view
            assign local_bp_enables[g]       = debug_control[2*g];
            assign global_bp_enables[g]      = debug_control[2*g+1];
            assign bp_kind_fields[2*g+1:2*g] = debug_control[`CTL_FIELD_BASE+4*g+1 -: 2];
            assign bp_size_fields[2*g+1:2*g] = debug_control[`CTL_FIELD_BASE+4*g+3 -: 2];
        end
    endgenerate

    // Breakpoint comparison on each monitored cycle.
    reg [3:0] bp_hit_flags;
    reg [3:0] bp_armed;
    reg       hit_exec;
    reg       hit_data;
    integer   i;
    always @* begin
        bp_hit_flags = 4'h0;
        bp_armed     = 4'h0;
        hit_exec     = 1'b0;
        hit_data     = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            // Matching is independent of enables; enables only arm exceptions.
            bp_hit_flags[i] = cyc_valid_in
                && kind_ok(bp_kind_fields[2*i+1 -: 2], cyc_kind_in, dbg_extensions_on)
                && hit(bp_addr[i], bp_size_fields[2*i+1 -: 2], cyc_addr_in); // RQ1
            bp_armed[i] = bp_hit_flags[i]
                && (local_bp_enables[i] || global_bp_enables[i]); // RQ10
            if (bp_armed[i] && bp_kind_fields[2*i+1 -: 2] == `KIND_EXEC) begin
                hit_exec = 1'b1; // RQ18
            end else if (bp_armed[i]) begin
                hit_data = 1'b1; // RQ17
            end
        end
    end

    // APB access decode; the access is taken in the first access cycle.
    // The guard is checked first, so a guarded alias access faults on vector 01h.
    wire       acc       = psel_in && penable_in && !pready_out;
    wire [3:0] idx       = paddr_in[5:2];
    wire       dr_space  = (paddr_in[5] == 1'b0);
    wire       alias_hit = dr_space
        && (idx == `IDX_ALIAS_FOUR || idx == `IDX_ALIAS_FIVE);
    wire       guard_hit = acc && dr_space && regaccess_guard_enable; // RQ6
    wire       undef_hit = acc && alias_hit && dbg_extensions_on && !guard_hit; // RQ3
    wire       do_acc    = acc && !guard_hit && !undef_hit;
    // Alias four reaches status and alias five reaches control.
    wire [3:0] eff_idx   = alias_hit ? idx + 4'h2 : idx; // RQ2

    // Exception sources in priority order.
    // An opcode trap in the same cycle as a debug event is dropped.
    wire step_ev  = insn_done_in && step_flag_in;          // RQ7
    wire task_ev  = task_switch_in && task_trap_in;        // RQ8
    wire trap_ev  = (trap_pend && insn_done_in) || step_ev || task_ev;
    wire fault_ev = hit_exec || guard_hit;                 // RQ18
    wire dbg_ev   = fault_ev || trap_ev;
    wire brk_ev   = brk_insn_done_in && !dbg_ev;           // RQ19

    // Read data mux for the taken access.
    // Reserved and write-only locations read as zero.
    reg [31:0] rd;
    always @* begin
        rd = 32'h00000000;
        if (dr_space) begin
            case (eff_idx)
                4'h0:         rd = bp_addr[0];
                4'h1:         rd = bp_addr[1];
                4'h2:         rd = bp_addr[2];
                4'h3:         rd = bp_addr[3];
                `IDX_STATUS:  rd = debug_status;
                `IDX_CONTROL: rd = debug_control;
                default:      rd = 32'h00000000;
            endcase
        end else begin
            case (paddr_in)
                `A_CONTROL_FOUR: rd = control_reg_four;
                `A_IRQ_STATUS:   rd = {29'h0, irq_status};
                `A_IRQ_ENABLE:   rd = {29'h0, irq_enable};
                default:         rd = 32'h00000000;
            endcase
        end
    end

    // Unmapped addresses lie above the clear register.
    // Misaligned addresses are refused as unmapped as well.
    wire mapped = (paddr_in <= `A_IRQ_CLEAR) && (paddr_in[1:0] == 2'h0);
    wire wr     = do_acc && pwrite_in && mapped;

    // APB answer: ready one cycle after the access phase begins.
    // Every access lasts two access cycles; its register effect lands at the first.
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end else begin
            pready_out  <= acc;
            pslverr_out <= acc && (guard_hit || undef_hit || !mapped);
            prdata_out  <= (do_acc && !pwrite_in && mapped) ? rd : 32'h00000000;
        end
    end

    // Breakpoint address registers.
    // Addresses are stored whole; the size field masks low bits only when comparing.
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            bp_addr[0] <= 32'h00000000;
            bp_addr[1] <= 32'h00000000;
            bp_addr[2] <= 32'h00000000;
            bp_addr[3] <= 32'h00000000;
        end else if (wr && dr_space && idx < 4'h4) begin
            bp_addr[idx[1:0]] <= pwdata_in; // RQ1
        end
    end

    // Debug control: software writes, task switch and exception updates.
    // A task switch clears the locals even after a same-cycle software write.
    reg [31:0] next_control;
    always @* begin
        next_control = debug_control;
        if (wr && dr_space && eff_idx == `IDX_CONTROL) begin
            // Compatibility bits are kept but feed no logic.
            next_control = pwdata_in & `CTL_WMASK; // RQ11
        end
        if (task_switch_in) begin
            next_control = next_control & 32'hFFFFFFAA; // RQ9
        end
        if (dbg_ev) begin
            next_control[`CTL_GUARD] = 1'b0; // RQ12
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            debug_control <= 32'h00000000;
        end else begin
            debug_control <= next_control;
        end
    end

    // Debug status: hardware sets win over a software write.
    // Software may clear sticky flags, but a same-cycle event keeps its own flag.
    reg [31:0] next_status;
    always @* begin
        next_status = debug_status;
        if (wr && dr_space && eff_idx == `IDX_STATUS) begin
            next_status = pwdata_in & `ST_WMASK;
        end
        next_status[3:0] = next_status[3:0] | bp_hit_flags; // RQ4 RQ5
        if (guard_hit) begin
            next_status[`ST_ACCESS] = 1'b1; // RQ6
        end
        if (step_ev) begin
            next_status[`ST_STEP] = 1'b1; // RQ7
        end
        if (task_ev) begin
            next_status[`ST_TASK] = 1'b1; // RQ8
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            debug_status <= 32'h00000000;
        end else begin
            debug_status <= next_status;
        end
    end

    // Control register four holds the debug extension enable.
    // Only the extension bit has a function; the other bits are kept for software.
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            control_reg_four <= 32'h00000000;
        end else if (wr && paddr_in == `A_CONTROL_FOUR) begin
            control_reg_four <= pwdata_in;
        end
    end

    // Data and port breakpoints wait for the instruction to retire.
    // A fresh data hit in a retire cycle stays pending for the next retirement.
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            trap_pend <= 1'b0;
        end else if (hit_data) begin
            trap_pend <= 1'b1; // RQ17
        end else if (trap_ev) begin
            trap_pend <= 1'b0;
        end
    end

    // Exception request, one-cycle pulse with vector and kind.
    // Debug events outrank the opcode trap, which outranks the undefined alias.
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            exc_valid_out  <= 1'b0;
            exc_vector_out <= 8'h00;
            exc_fault_out  <= 1'b0;
        end else begin
            exc_valid_out  <= dbg_ev || brk_ev || undef_hit;
            exc_fault_out  <= fault_ev || (undef_hit && !trap_ev); // RQ18
            if (dbg_ev) begin
                exc_vector_out <= `VEC_DEBUG; // RQ17 RQ18
            end else if (brk_ev) begin
                exc_vector_out <= `VEC_BREAK; // RQ19
            end else if (undef_hit) begin
                exc_vector_out <= `VEC_UNDEF; // RQ3
            end else begin
                exc_vector_out <= 8'h00;
            end
        end
    end

    // Interrupt status: sticky, set wins over clear.
    // The output looks ahead at next status and enable, so it follows without lag.
    wire [2:0] irq_set = {undef_hit, brk_ev, dbg_ev};
    wire [2:0] irq_clr = (wr && paddr_in == `A_IRQ_CLEAR) ? pwdata_in[2:0] : 3'h0;
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_status <= 3'h0;
            irq_enable <= 3'h0;
            irq_out    <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            if (wr && paddr_in == `A_IRQ_ENABLE) begin
                irq_enable <= pwdata_in[2:0];
            end
            irq_out <= |(((irq_status & ~irq_clr) | irq_set)
                        & ((wr && paddr_in == `A_IRQ_ENABLE) ? pwdata_in[2:0] : irq_enable));
        end
    end

endmodule
`default_nettype wire

// file: test/breakpoint_debug_unit_chk.sv
// Port checker for the breakpoint debug unit.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module breakpoint_debug_unit_chk (
    // Clock, reset and watched inputs.
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        cyc_valid_in,
    input wire logic        insn_done_in,
    input wire logic        step_flag_in,
    input wire logic        brk_insn_done_in,
    input wire logic        task_switch_in,
    input wire logic        task_trap_in,
    // Watched outputs.
    input wire logic        exc_valid_out,
    input wire logic [7:0]  exc_vector_out,
    input wire logic        exc_fault_out
);
    // Every check runs on the core clock and rests during reset.
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // No bus access and no cycle that could raise a competing fault.
    wire quiet = !cyc_valid_in && !psel_in;
    wire exv1 = exc_valid_out && exc_vector_out == 8'h01;

    a_step_trap: assert property (
        insn_done_in && step_flag_in && quiet && !task_switch_in
        |=> exv1 && !exc_fault_out) else $error("step trap missing");
    a_task_trap: assert property (
        task_switch_in && task_trap_in && quiet && !insn_done_in
        |=> exv1 && !exc_fault_out) else $error("task trap missing");
    a_brk_trap: assert property (
        brk_insn_done_in && quiet && !insn_done_in && !task_switch_in
        |=> exc_valid_out && exc_vector_out == 8'h03 && !exc_fault_out)
        else $error("breakpoint opcode trap missing");
    a_trap_cause: assert property (
        exv1 && !exc_fault_out |-> $past(insn_done_in) || $past(task_switch_in))
        else $error("debug trap without a finished instruction");
    a_fault_cause: assert property (
        exv1 && exc_fault_out |-> $past(cyc_valid_in) || $past(psel_in && penable_in))
        else $error("debug fault without a cycle or access");
    a_undef_fault: assert property (
        exc_valid_out && exc_vector_out == 8'h06
        |-> exc_fault_out && $past(psel_in && penable_in))
        else $error("undefined opcode not a bus fault");
    a_vec_legal: assert property (
        exc_valid_out |-> exc_vector_out inside {8'h01, 8'h03, 8'h06})
        else $error("illegal exception vector");
    a_brk_kind: assert property (
        exc_valid_out && exc_vector_out == 8'h03 |-> $past(brk_insn_done_in))
        else $error("breakpoint vector without its opcode");

    // Main scenarios reached.
    c_fault: cover property (exv1 && exc_fault_out);
    c_trap: cover property (exv1 && !exc_fault_out);
    c_undef: cover property (exc_valid_out && exc_vector_out == 8'h06);
endmodule
bind breakpoint_debug_unit breakpoint_debug_unit_chk chk_i (
    .ref_clk_in, .rst_in, .psel_in, .penable_in, .cyc_valid_in, .insn_done_in,
    .step_flag_in, .brk_insn_done_in, .task_switch_in, .task_trap_in, .exc_valid_out,
    .exc_vector_out, .exc_fault_out
);
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the breakpoint debug unit.
// Assumes the register map header and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
`include "bp_debug_map.vh"
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [5:0]  padr = 6'h00;
    logic [31:0] pwd = 32'h00000000;
    logic [31:0] prd;
    logic        prdy;
    logic        perr;
    logic        cv = 1'b0;
    logic [1:0]  ck = 2'h0;
    logic [31:0] ca = 32'h00000000;
    logic [2:0]  ev = 3'h0;
    logic        step = 1'b0;
    logic        ttrap = 1'b0;
    logic        exv;
    logic [7:0]  exvec;
    logic        exf;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    logic [7:0]  lvec;
    logic        lflt;
    int          fail_count = 0;
    int          checked = 0;
    int          exc_n = 0;
    int          exc_old = 0;
    int          cycles = 0;

    // Unit under test; ev carries task switch, opcode CCh and retire pulses.
    breakpoint_debug_unit breakpoint_debug_unit_i (
        .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .cyc_valid_in(cv),
        .cyc_kind_in(ck), .cyc_addr_in(ca), .insn_done_in(ev[0]),
        .step_flag_in(step), .brk_insn_done_in(ev[1]), .task_switch_in(ev[2]),
        .task_trap_in(ttrap), .exc_valid_out(exv), .exc_vector_out(exvec),
        .exc_fault_out(exf), .irq_out(irq));

    // Free-running core clock.
    initial begin
        forever #2 clk = ~clk;
    end

    // Exceptions are counted mid-cycle, where the outputs have settled.
    always @(negedge clk) begin
        if (exv === 1'b1) begin
            exc_n++;
            lvec = exvec;
            lflt = exf;
        end
    end

    // A hang is cut short and reported as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the answer is taken at the edge that sees pready.
    task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rdat = prd;
        rerr = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cmp("write error", 32'h0, {31'h0, rerr});
    endtask

    task automatic rd(input string what, input logic [5:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(what, exp, rdat);
    endtask

    // Core pulses and processor cycles last one clock each.
    task automatic evt(input logic [2:0] b);
        @(posedge clk);
        ev <= b;
        @(posedge clk);
        ev <= 3'h0;
    endtask

    task automatic cyc(input logic [1:0] k, input logic [31:0] a);
        @(posedge clk);
        cv <= 1'b1;
        ck <= k;
        ca <= a;
        @(posedge clk);
        cv <= 1'b0;
    endtask

    // Checks how many exceptions came since the last call, and the last one.
    task automatic exc(input int n, input logic [7:0] v, input logic f);
        repeat (3) @(posedge clk);
        cmp("exception count", n, exc_n - exc_old);
        if (n > 0) begin
            cmp("vector", {24'h0, v}, {24'h0, lvec});
            cmp("fault", {31'h0, f}, {31'h0, lflt});
        end
        exc_old = exc_n;
    endtask

    // Main sequence of tests.
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            wr(6'(n * 4), 32'hA5C30000 + n);
            rd("bp address", 6'(n * 4), 32'hA5C30000 + n);
        end
        apb(1'b0, 6'h30, 32'h0);
        cmp("unmapped error", 32'h1, {31'h0, rerr});
        cmp("unmapped data", 32'h0, rdat);
        $display("registers test done");
        wr(`A_BP_ADDR_ZERO, 32'h00001000);
        wr(`A_BP_ADDR_ONE, 32'h00002000);
        wr(`A_BP_ADDR_TWO, 32'h00002002);
        wr(`A_BP_ADDR_THREE, 32'h00003000);
        wr(`A_DEBUG_CONTROL, 32'h00002002);
        cyc(`CYC_FETCH, 32'h00001000);
        exc(1, `VEC_DEBUG, 1'b1);
        rd("status", `A_DEBUG_STATUS, 32'h00000001);
        rd("control", `A_DEBUG_CONTROL, 32'h00000002);
        $display("execute breakpoint test done");
        wr(`A_DEBUG_CONTROL, 32'h00002002);
        apb(1'b0, `A_BP_ADDR_ZERO, 32'h0);
        cmp("guard error", 32'h1, {31'h0, rerr});
        exc(1, `VEC_DEBUG, 1'b1);
        rd("status", `A_DEBUG_STATUS, 32'h00002001);
        $display("access guard test done");
        wr(`A_DEBUG_STATUS, 32'h0);
        wr(`A_DEBUG_CONTROL, 32'h01D00006);
        cyc(`CYC_WRITE, 32'h00002002);
        exc(0, 8'h00, 1'b0);
        evt(3'h1);
        exc(1, `VEC_DEBUG, 1'b0);
        rd("status", `A_DEBUG_STATUS, 32'h00000006);
        wr(`A_DEBUG_STATUS, 32'h0);
        cyc(`CYC_READ, 32'h00002002);
        cyc(`CYC_WRITE, 32'h00002004);
        evt(3'h1);
        exc(0, 8'h00, 1'b0);
        rd("status", `A_DEBUG_STATUS, 32'h0);
        $display("data breakpoint test done");
        ttrap <= 1'b1;
        evt(3'h4);
        exc(1, `VEC_DEBUG, 1'b0);
        ttrap <= 1'b0;
        rd("status", `A_DEBUG_STATUS, 32'h00008000);
        rd("control", `A_DEBUG_CONTROL, 32'h01D00002);
        wr(`A_DEBUG_STATUS, 32'h0);
        step <= 1'b1;
        evt(3'h1);
        exc(1, `VEC_DEBUG, 1'b0);
        step <= 1'b0;
        rd("status", `A_DEBUG_STATUS, 32'h00004000);
        evt(3'h2);
        exc(1, `VEC_BREAK, 1'b0);
        $display("task, step and opcode test done");
        wr(`A_ALIAS_FIVE, 32'h00000302);
        rd("control", `A_DEBUG_CONTROL, 32'h00000302);
        rd("alias four", `A_ALIAS_FOUR, 32'h00004000);
        wr(`A_CONTROL_FOUR, 32'h00000008);
        apb(1'b1, `A_ALIAS_FIVE, 32'h0);
        cmp("alias error", 32'h1, {31'h0, rerr});
        exc(1, `VEC_UNDEF, 1'b1);
        rd("control", `A_DEBUG_CONTROL, 32'h00000302);
        wr(`A_CONTROL_FOUR, 32'h0);
        $display("alias test done");
        wr(`A_DEBUG_STATUS, 32'h0);
        wr(`A_DEBUG_CONTROL, 32'h0072000A);
        cyc(`CYC_IO, 32'h00001000);
        cyc(`CYC_WRITE, 32'h00002002);
        cyc(`CYC_READ, 32'h00002001);
        evt(3'h1);
        exc(1, `VEC_DEBUG, 1'b0);
        rd("status", `A_DEBUG_STATUS, 32'h00000002);
        wr(`A_CONTROL_FOUR, 32'h00000008);
        cyc(`CYC_IO, 32'h00001000);
        evt(3'h1);
        exc(1, `VEC_DEBUG, 1'b0);
        rd("status", `A_DEBUG_STATUS, 32'h00000003);
        wr(`A_CONTROL_FOUR, 32'h0);
        $display("port and size test done");
        rd("irq status", `A_IRQ_STATUS, 32'h00000007);
        cmp("irq masked", 32'h0, {31'h0, irq});
        wr(`A_IRQ_ENABLE, 32'h00000001);
        repeat (2) @(posedge clk);
        cmp("irq raised", 32'h1, {31'h0, irq});
        wr(`A_IRQ_CLEAR, 32'h00000001);
        repeat (2) @(posedge clk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        rd("irq status", `A_IRQ_STATUS, 32'h00000006);
        $display("interrupt test done");
        print_verdict();
    end
endmodule
`default_nettype wire
